// *** logic/mpt_defs.svh ***
`ifndef MPT_DEFS_SVH
`define MPT_DEFS_SVH

// Register byte offsets.
`define MPT_OFS_STATUS 8'h00
`define MPT_OFS_TCR 8'h04
`define MPT_OFS_TC 8'h08
`define MPT_OFS_PR 8'h0C
`define MPT_OFS_PC 8'h10
`define MPT_OFS_MCR 8'h14
`define MPT_OFS_MR0 8'h18
`define MPT_OFS_MR6 8'h30
`define MPT_OFS_PCR 8'h34
`define MPT_OFS_LER 8'h38
`define MPT_OFS_MASK 8'h3C

// Timer control bits.
`define MPT_TCR_EN 0
`define MPT_TCR_RST 1
`define MPT_TCR_PWM 3

// Match control: three bits per match register, lowest field first.
`define MPT_MCR_INT 0
`define MPT_MCR_RST 1
`define MPT_MCR_STOP 2
`define MPT_MCR_W 21

// Output control: double-edge selects for outputs 2..6, enables for outputs 1..6.
`define MPT_PCR_DBL_LO 2
`define MPT_PCR_OE_LO 9

// Reset values.
`define MPT_RST_WORD 32'h0000_0000
`define MPT_RST_CHAN 7'h00
`define MPT_RST_OUT 6'h00

// Counts.
`define MPT_NUM_MATCH 7
`define MPT_NUM_OUT 6

`endif

// *** logic/mpt_pkg.sv ***
`default_nettype none
package mpt_pkg;
  typedef logic [31:0] mpt_word_t;
  typedef logic [6:0] mpt_chan_t;
  typedef logic [5:0] mpt_out_t;
  typedef logic [2:0] mpt_idx_t;
endpackage : mpt_pkg
`default_nettype wire

// *** logic/mpt_match_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defs.svh"
module mpt_match_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire mpt_pkg::mpt_word_t shadow_i,
  input wire mpt_pkg::mpt_word_t tc_i,
  input wire logic tick_i,
  output mpt_pkg::mpt_word_t act_o,
  output logic match_o
);
  mpt_pkg::mpt_word_t act_r;

  // The comparator only sees the effective value, never the shadow copy.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      act_r <= `MPT_RST_WORD;
    else if (ce_i && load_i)
      act_r <= shadow_i;
  end

  assign act_o = act_r;
  assign match_o = tick_i && (tc_i == act_r);

  AST_HOLD_UNTIL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !load_i |=> act_o == $past(act_o))
    else $error("Effective match value changed without a release.");

  AST_LOAD_TAKES: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && load_i |=> act_o == $past(shadow_i))
    else $error("Released match value did not become effective.");
endmodule : mpt_match_unit
`default_nettype wire

// *** logic/mpt_top.sv ***
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defs.svh"
// Functional notes
// - Seven match registers compare against the count for interrupts, actions, outputs.
// - Cycle match resets the count, starting a new cycle for all outputs.
// - Single edge output changes level at its own match position.
// - Single edge outputs go high at each cycle start unless held low.
// - Double edge output: one match sets, another clears, anywhere in cycle.
// - Set before clear gives positive pulse; clear before set gives negative.
// - Six single edge or three double edge outputs, or any mixture.
// - Each match may interrupt, and may continue, stop or reset the timer.
// - In PWM mode, released match values take effect only at a cycle boundary; timer mode loads them at once.
// - Without PWM mode the block is a plain match timer, outputs idle.
// - 32-bit counter advancing under a programmable 32-bit prescaler.
// - The timer counts clock cycles divided by the prescaler value plus one.
// - Period and widths are any count; all outputs share one period.
module mpt_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire mpt_pkg::mpt_word_t wb_dat_i,
  output mpt_pkg::mpt_word_t wb_dat_o,
  output logic wb_ack_o,
  output mpt_pkg::mpt_out_t pwm_o,
  output logic irq_o
);
  function automatic mpt_pkg::mpt_word_t merge_bytes(input mpt_pkg::mpt_word_t old_v,
                                                      input mpt_pkg::mpt_word_t new_v,
                                                      input logic [3:0] sel);
    mpt_pkg::mpt_word_t res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    end
    return res;
  endfunction : merge_bytes

  function automatic mpt_pkg::mpt_chan_t mcr_field(input logic [`MPT_MCR_W-1:0] mcr,
                                                    input int unsigned k);
    mpt_pkg::mpt_chan_t res;
    res = `MPT_RST_CHAN;
    for (int i = 0; i < `MPT_NUM_MATCH; i++)
      res[i] = mcr[3*i + k];
    return res;
  endfunction : mcr_field

  logic ack_r;
  mpt_pkg::mpt_word_t dat_r;
  mpt_pkg::mpt_chan_t status_r;
  mpt_pkg::mpt_chan_t mask_r;
  mpt_pkg::mpt_chan_t ler_r;
  logic cnt_en_r;
  logic cnt_rst_r;
  logic pwm_en_r;
  mpt_pkg::mpt_word_t tc_r;
  mpt_pkg::mpt_word_t pr_r;
  mpt_pkg::mpt_word_t pc_r;
  logic [`MPT_MCR_W-1:0] mcr_r;
  logic [4:0] dbl_r;
  mpt_pkg::mpt_out_t oe_r;
  mpt_pkg::mpt_out_t pwm_r;
  logic irq_r;
  mpt_pkg::mpt_word_t shadow_r [0:`MPT_NUM_MATCH-1];

  // Bus decode: a write commits on the edge at which the master sees ack.
  wire req = wb_cyc_i && wb_stb_i;
  wire ack_nxt = req && !ack_r;
  wire wr = req && ack_r && wb_we_i;
  wire [7:0] mr_off = wb_adr_i - `MPT_OFS_MR0;
  wire hit_mr = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i >= `MPT_OFS_MR0)
                && (wb_adr_i <= `MPT_OFS_MR6);
  wire [2:0] mr_idx = mr_off[4:2];
  wire wr_status = wr && (wb_adr_i == `MPT_OFS_STATUS);
  wire wr_tcr = wr && (wb_adr_i == `MPT_OFS_TCR);
  wire wr_tc = wr && (wb_adr_i == `MPT_OFS_TC);
  wire wr_pr = wr && (wb_adr_i == `MPT_OFS_PR);
  wire wr_mcr = wr && (wb_adr_i == `MPT_OFS_MCR);
  wire wr_pcr = wr && (wb_adr_i == `MPT_OFS_PCR);
  wire wr_ler = wr && (wb_adr_i == `MPT_OFS_LER);
  wire wr_mask = wr && (wb_adr_i == `MPT_OFS_MASK);
  wire wr_mr = wr && hit_mr;
  wire mpt_pkg::mpt_word_t wmask = merge_bytes(`MPT_RST_WORD, 32'hFFFF_FFFF, wb_sel_i);
  wire mpt_pkg::mpt_word_t wdat = wb_dat_i & wmask;

  wire mpt_pkg::mpt_word_t tcr_view = {28'h000_0000, pwm_en_r, 1'b0, cnt_rst_r, cnt_en_r};
  wire mpt_pkg::mpt_word_t pcr_view = {17'h0_0000, oe_r, 2'h0, dbl_r, 2'h0};
  wire mpt_pkg::mpt_word_t rd_mux =
    (wb_adr_i == `MPT_OFS_STATUS) ? {25'h000_0000, status_r} :
    (wb_adr_i == `MPT_OFS_TCR) ? tcr_view :
    (wb_adr_i == `MPT_OFS_TC) ? tc_r :
    (wb_adr_i == `MPT_OFS_PR) ? pr_r :
    (wb_adr_i == `MPT_OFS_PC) ? pc_r :
    (wb_adr_i == `MPT_OFS_MCR) ? {11'h000, mcr_r} :
    hit_mr ? shadow_r[mr_idx] :
    (wb_adr_i == `MPT_OFS_PCR) ? pcr_view :
    (wb_adr_i == `MPT_OFS_LER) ? {25'h000_0000, ler_r} :
    (wb_adr_i == `MPT_OFS_MASK) ? {25'h000_0000, mask_r} :
    `MPT_RST_WORD;

  // Counter core.
  wire tick = cnt_en_r && !cnt_rst_r && (pc_r == pr_r);
  wire mpt_pkg::mpt_chan_t evt;
  wire mpt_pkg::mpt_word_t act [0:`MPT_NUM_MATCH-1];
  wire mpt_pkg::mpt_chan_t mcr_int = mcr_field(mcr_r, `MPT_MCR_INT);
  wire mpt_pkg::mpt_chan_t mcr_rst = mcr_field(mcr_r, `MPT_MCR_RST);
  wire mpt_pkg::mpt_chan_t mcr_stop = mcr_field(mcr_r, `MPT_MCR_STOP);
  wire rst_evt = |(evt & mcr_rst);
  wire stop_evt = |(evt & mcr_stop);
  wire cycle_start = rst_evt || cnt_rst_r;
  // In timer mode match writes pass straight through; in PWM mode only released
  // values move, and only at a cycle boundary.
  wire mpt_pkg::mpt_chan_t ler_take = (pwm_en_r && cycle_start) ? ler_r : `MPT_RST_CHAN;
  wire mpt_pkg::mpt_chan_t load = pwm_en_r ? ler_take : 7'h7F;

  genvar g;
  generate
    for (g = 0; g < `MPT_NUM_MATCH; g++)
    begin : g_match
      mpt_match_unit u_match (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(load[g]),
        .shadow_i(shadow_r[g]),
        .tc_i(tc_r),
        .tick_i(tick),
        .act_o(act[g]),
        .match_o(evt[g])
      );
    end
  endgenerate

  wire mpt_pkg::mpt_word_t tc_inc = tc_r + 32'h0000_0001;
  wire mpt_pkg::mpt_word_t pc_inc = pc_r + 32'h0000_0001;
  wire mpt_pkg::mpt_word_t tc_nxt = cnt_rst_r ? `MPT_RST_WORD :
                                   wr_tc ? merge_bytes(tc_r, wb_dat_i, wb_sel_i) :
                                   !tick ? tc_r :
                                   rst_evt ? `MPT_RST_WORD : tc_inc;
  wire mpt_pkg::mpt_word_t pc_nxt = (cnt_rst_r || tick) ? `MPT_RST_WORD :
                                   cnt_en_r ? pc_inc : pc_r;
  wire en_nxt = wr_tcr && wb_sel_i[0] ? wb_dat_i[`MPT_TCR_EN] : (cnt_en_r && !stop_evt);

  // PWM edges: output 1 is single edge only; outputs 2..6 can use two matches.
  wire mpt_pkg::mpt_out_t pset;
  wire mpt_pkg::mpt_out_t pclr;
  assign pset[0] = evt[0];
  assign pclr[0] = evt[1];
  generate
    for (g = 1; g < `MPT_NUM_OUT; g++)
    begin : g_edge
      assign pset[g] = dbl_r[g-1] ? evt[g] : evt[0];
      assign pclr[g] = evt[g+1];
    end
  endgenerate
  // A clear on the same step as a set wins, so an edge equal to the cycle
  // match gives a constant low output.
  wire mpt_pkg::mpt_out_t pwm_nxt = (pwm_en_r ? oe_r : `MPT_RST_OUT)
                                    & ~pclr & (pset | pwm_r);

  // Sticky flags: a new event wins over a simultaneous write-one clear.
  wire mpt_pkg::mpt_chan_t clr_bits = wr_status ? wdat[6:0] : `MPT_RST_CHAN;
  wire mpt_pkg::mpt_chan_t status_nxt = (status_r & ~clr_bits) | (evt & mcr_int);
  wire mpt_pkg::mpt_word_t mask_merged = merge_bytes({25'h000_0000, mask_r}, wb_dat_i, wb_sel_i);
  wire mpt_pkg::mpt_chan_t mask_nxt = wr_mask ? mask_merged[6:0] : mask_r;
  wire mpt_pkg::mpt_word_t mcr_merged = merge_bytes({11'h000, mcr_r}, wb_dat_i, wb_sel_i);
  wire mpt_pkg::mpt_chan_t ler_nxt = (ler_r & ~ler_take) | (wr_ler ? wdat[6:0] : `MPT_RST_CHAN);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= `MPT_RST_WORD;
      irq_r <= 1'b0;
      status_r <= `MPT_RST_CHAN;
      mask_r <= `MPT_RST_CHAN;
      ler_r <= `MPT_RST_CHAN;
    end
    else if (ce_i)
    begin
      ack_r <= ack_nxt;
      dat_r <= ack_nxt ? rd_mux : `MPT_RST_WORD;
      irq_r <= |(status_nxt & mask_nxt);
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ler_r <= ler_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_en_r <= 1'b0;
      cnt_rst_r <= 1'b0;
      pwm_en_r <= 1'b0;
      tc_r <= `MPT_RST_WORD;
      pc_r <= `MPT_RST_WORD;
      pr_r <= `MPT_RST_WORD;
      mcr_r <= '0;
      dbl_r <= 5'h00;
      oe_r <= `MPT_RST_OUT;
      pwm_r <= `MPT_RST_OUT;
    end
    else if (ce_i)
    begin
      cnt_en_r <= en_nxt;
      if (wr_tcr && wb_sel_i[0])
      begin
        cnt_rst_r <= wb_dat_i[`MPT_TCR_RST];
        pwm_en_r <= wb_dat_i[`MPT_TCR_PWM];
      end
      tc_r <= tc_nxt;
      pc_r <= pc_nxt;
      if (wr_pr)
        pr_r <= merge_bytes(pr_r, wb_dat_i, wb_sel_i);
      if (wr_mcr)
        mcr_r <= mcr_merged[`MPT_MCR_W-1:0];
      if (wr_pcr)
      begin
        dbl_r <= wb_dat_i[`MPT_PCR_DBL_LO +: 5];
        oe_r <= wb_dat_i[`MPT_PCR_OE_LO +: 6];
      end
      pwm_r <= pwm_nxt;
    end
  end

  // Shadows are cleared so that timer mode never loads an unknown compare value.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `MPT_NUM_MATCH; i++)
        shadow_r[i] <= `MPT_RST_WORD;
    end
    else if (ce_i && wr_mr)
      shadow_r[mr_idx] <= merge_bytes(shadow_r[mr_idx], wb_dat_i, wb_sel_i);
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pwm_o = pwm_r;
  assign irq_o = irq_r;

  AST_CYCLE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tick && evt[0] && mcr_rst[0] && !wr_tc |=> tc_r == 32'h0000_0000
      && pc_r == 32'h0000_0000)
    else $error("Cycle match did not restart the count.");

  AST_PRESCALE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !wr_tc && !cnt_rst_r && pc_r != pr_r |=> tc_r == $past(tc_r))
    else $error("Count advanced before the prescaler expired.");

  AST_COUNT_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tick && !rst_evt && !wr_tc |=> tc_r == $past(tc_r) + 32'h0000_0001)
    else $error("Count did not step on a prescaler expiry.");

  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && |(evt & mcr_int) |=> (status_r & $past(evt & mcr_int)) == $past(evt & mcr_int))
    else $error("Match event did not set its flag.");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == |(status_r & mask_r))
    else $error("Interrupt output disagrees with enabled flags.");

  AST_STOP_ON_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && stop_evt && !wr_tcr |=> !cnt_en_r ##1 (!ce_i || tc_r == $past(tc_r)))
    else $error("Stop on match left the timer running.");

  AST_SINGLE_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pwm_en_r && oe_r[0] && evt[0] && !evt[1] |=> pwm_o[0])
    else $error("Single edge output did not rise at cycle start.");

  AST_DOUBLE_EDGES: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pwm_en_r && oe_r[1] && dbl_r[0] && (evt[1] || evt[2])
      |=> pwm_o[1] == !$past(evt[2]))
    else $error("Double edge output missed its set or clear match.");

  AST_PWM_LOAD_BOUNDARY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pwm_en_r && !cycle_start |=> act[0] == $past(act[0]))
    else $error("Cycle match value moved inside a PWM cycle.");

  AST_TIMER_MODE_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pwm_en_r |=> pwm_o == 6'h00)
    else $error("Outputs moved while PWM mode was off.");
endmodule : mpt_top
`default_nettype wire

// *** sim/mpt_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Load on the outputs: counts high samples of outputs 1 and 2 and rising edges of output 1.
module mpt_load_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire mpt_pkg::mpt_out_t pwm_i,
  output int hi0_o,
  output int hi1_o,
  output int rise_o
);
  logic last_r;
  always_ff @(posedge clk_i)
  begin
    last_r <= pwm_i[0];
    if (clr_i)
    begin
      hi0_o <= 0;
      hi1_o <= 0;
      rise_o <= 0;
    end
    else
    begin
      hi0_o <= hi0_o + int'(pwm_i[0]);
      hi1_o <= hi1_o + int'(pwm_i[1]);
      rise_o <= rise_o + int'(pwm_i[0] & ~last_r);
    end
  end
endmodule : mpt_load_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defs.svh"
module testbench;
  typedef struct {int pr; int m0; int m1; int m2; int pcr; int h0; int h1; int r;} mpt_row_t;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, clr;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  mpt_pkg::mpt_word_t wb_dat_i, wb_dat_o, rd;
  mpt_pkg::mpt_out_t pwm_o;
  int hi0, hi1, rise, mismatches, tests_run, cycles;
  mpt_row_t rows [5] = '{'{0, 3, 1, 2, 'h600, 30, 45, 15}, '{0, 4, 1, 3, 'h604, 24, 24, 12},
    '{0, 4, 3, 1, 'h604, 48, 36, 12}, '{2, 3, 1, 2, 'h600, 30, 45, 5},
    '{0, 3, 1, 2, 'h200, 30, 0, 15}};
  mpt_top mpt_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_o(pwm_o),
    .irq_o(irq_o));
  mpt_load_model mpt_load_model_inst (.clk_i(clk_i), .clr_i(clr), .pwm_i(pwm_o),
    .hi0_o(hi0), .hi1_o(hi1), .rise_o(rise));
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input mpt_pkg::mpt_word_t got, input mpt_pkg::mpt_word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input mpt_pkg::mpt_word_t d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Counts exactly 60 clocks, a whole number of periods for every row.
  task automatic measure();
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (61) @(posedge clk_i);
  endtask : measure
  task automatic cfg(input int k);
    wb(1'b1, `MPT_OFS_TCR, 32'h0000_000A);
    wb(1'b1, `MPT_OFS_PR, 32'(rows[k].pr));
    wb(1'b1, `MPT_OFS_MCR, 32'h0000_0002);
    wb(1'b1, `MPT_OFS_MR0, 32'(rows[k].m0));
    wb(1'b1, `MPT_OFS_MR0 + 8'h04, 32'(rows[k].m1));
    wb(1'b1, `MPT_OFS_MR0 + 8'h08, 32'(rows[k].m2));
    wb(1'b1, `MPT_OFS_PCR, 32'(rows[k].pcr));
    wb(1'b1, `MPT_OFS_LER, 32'h0000_0007);
    wb(1'b1, `MPT_OFS_TCR, 32'h0000_0009);
    repeat (20) @(posedge clk_i);
  endtask : cfg
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  initial
  begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, clr} = 6'h31;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Every register clears on reset; 0x40 is unmapped and reads zero.
    for (int i = 0; i <= 16; i++)
    begin
      wb(1'b0, 8'(i * 4), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    for (int k = 0; k < 5; k++)
    begin
      cfg(k);
      measure();
      chk(32'(hi0), 32'(rows[k].h0));
      chk(32'(hi1), 32'(rows[k].h1));
      chk(32'(rise), 32'(rows[k].r));
    end
    cfg(1);
    wb(1'b1, `MPT_OFS_MR0 + 8'h04, 32'h0000_0003);
    wb(1'b1, `MPT_OFS_MR0 + 8'h08, 32'h0000_0001);
    measure();
    chk(32'(hi0), 32'd24);
    chk(32'(hi1), 32'd24);
    wb(1'b1, `MPT_OFS_LER, 32'h0000_0006);
    repeat (20) @(posedge clk_i);
    measure();
    chk(32'(hi0), 32'd48);
    chk(32'(hi1), 32'd36);
    // Timer mode: match 0 interrupts and stops the count.
    wb(1'b1, `MPT_OFS_TCR, 32'h0000_0002);
    wb(1'b1, `MPT_OFS_MCR, 32'h0000_0005);
    wb(1'b1, `MPT_OFS_MR0, 32'h0000_0005);
    wb(1'b1, `MPT_OFS_MASK, 32'h0000_0001);
    wb(1'b1, `MPT_OFS_TCR, 32'h0000_0001);
    repeat (30) @(posedge clk_i);
    wb(1'b0, `MPT_OFS_TCR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b0, `MPT_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(32'(irq_o), 32'h0000_0001);
    chk(32'(pwm_o), 32'h0000_0000);
    wb(1'b1, `MPT_OFS_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0000_0000);
    wb(1'b1, `MPT_OFS_STATUS, 32'h0000_0001);
    wb(1'b0, `MPT_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // A reset in mid-run returns outputs and control to idle.
    cfg(0);
    // Clock enable low freezes the outputs; two steps would otherwise flip output 1.
    ce_i <= 1'b0;
    @(posedge clk_i);
    rd = 32'(pwm_o);
    repeat (2) @(posedge clk_i);
    chk(32'(pwm_o), rd);
    ce_i <= 1'b1;
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(pwm_o), 32'h0000_0000);
    wb(1'b0, `MPT_OFS_TCR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    summarize();
  end
endmodule : testbench
`default_nettype wire
